// ==== logic/rfb_bank.sv ====
`timescale 1ns/1ps
module rfb_bank (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // access request
  input wire logic write_i,
  input wire logic indirect_i,
  input wire logic read_i,
  input wire logic [1:0] addr_i,
  input wire logic [31:0] write_data_i,
  input wire logic context_reserved_i,
  // answer
  output logic [31:0] read_data_o,
  output logic read_valid_o,
  // function bits that steer the device
  output logic [31:0] control_o
);
  // register map of bit classes: 0 rw with reserved fields, 1 ro, 2 wo, 3 context reg
  function automatic rfb_pkg::rfb_class_type class_of(input int r, input int b);
    if (r == 0) begin
      if (b < 8) return rfb_pkg::rfb_normal;
      if (b < 12) return rfb_pkg::rfb_reserved_zero_bit;
      if (b < 16) return rfb_pkg::rfb_reserved_one_bit;
      if (b < 20) return rfb_pkg::rfb_reads_as_zero_field;
      if (b < 24) return rfb_pkg::rfb_reads_as_one_field;
      return rfb_pkg::rfb_reserved_zero_bit;
    end else if (r == 1) begin
      if (b < 16) return rfb_pkg::rfb_unknown_reading_field;
      return rfb_pkg::rfb_reserved_one_bit;
    end else if (r == 2) begin
      return rfb_pkg::rfb_reserved_zero_bit;
    end
    if (b < 16) return rfb_pkg::rfb_context_bit;
    return rfb_pkg::rfb_normal;
  endfunction : class_of
  // odd fields tied, even stored, chosen per field of four bits; every bit of reg1 is tied
  // reg0 [15:14] is a field of its own: a stored reserved-one pair
  function automatic rfb_pkg::rfb_impl_type impl_of(input int r, input int b);
    if (r == 1) return rfb_pkg::rfb_tied;
    if (r == 0 && b >= 14 && b < 16) return rfb_pkg::rfb_stored;
    return ((b / 4) % 2 == 1) ? rfb_pkg::rfb_tied : rfb_pkg::rfb_stored;
  endfunction : impl_of
  function automatic logic reset_of(input int r, input int b);
    if (class_of(r, b) == rfb_pkg::rfb_reserved_one_bit) return rfb_pkg::stored_one_reset[b];
    return rfb_pkg::reset_value[b];
  endfunction : reset_of

  typedef struct packed {
    logic [31:0] read_data;
    logic read_valid;
    logic [31:0] control;
  } rfb_bank_state_type;
  rfb_bank_state_type state;
  rfb_bank_state_type next_state;

  logic [3:0][31:0] bit_read;
  logic [3:0][31:0] bit_func;
  logic [3:0] reg_sel;

  genvar gr, gb;
  generate
    for (gr = 0; gr < 4; gr++) begin : g_reg
      assign reg_sel[gr] = (addr_i == 2'(gr));
      for (gb = 0; gb < 32; gb++) begin : g_bit
        rfb_bit #(
          .bit_class(class_of(gr, gb)),
          .bit_impl(impl_of(gr, gb)),
          .reset_bit(reset_of(gr, gb))
        ) u_bit (
          .mclk_i(mclk_i),
          .reset_i(reset_i),
          .direct_write_i(write_i && !indirect_i && reg_sel[gr] && gr != 1),
          .indirect_write_i(write_i && indirect_i && reg_sel[gr] && gr != 1),
          .write_data_i(write_data_i[gb]),
          .context_reserved_i(context_reserved_i),
          .read_data_o(bit_read[gr][gb]),
          .function_o(bit_func[gr][gb])
        );
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.read_valid = read_i;
    if (read_i) begin
      // write-only register reads zero
      next_state.read_data = (addr_i == 2'h2) ? rfb_pkg::zero_word : bit_read[addr_i];
    end
    next_state.control = bit_func[0] | bit_func[3];
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '{read_data: rfb_pkg::zero_word, read_valid: 1'b0, control: rfb_pkg::zero_word};
    end else begin
      state <= next_state;
    end
  end

  assign read_data_o = state.read_data;
  assign read_valid_o = state.read_valid;
  assign control_o = state.control;

  zero_field_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    read_i && addr_i == 2'h0 |=> read_data_o[19:16] == 4'h0)
    else $error("reads-as-zero field read nonzero");
  one_field_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    read_i && addr_i == 2'h0 |=> read_data_o[23:20] == 4'hf)
    else $error("reads-as-one field read not all ones");
  tied_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    read_i && addr_i == 2'h0 |=> read_data_o[31:28] == 4'h0)
    else $error("tied reserved zero read nonzero");
  tied_one_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    read_i && addr_i == 2'h0 |=> read_data_o[13:12] == 2'h3)
    else $error("tied reserved one read not ones");
  unknown_ro_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    read_i && addr_i == 2'h1 |=> read_data_o == 32'hffff_0000)
    else $error("read-only register wrong");
  wo_read_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    read_i && addr_i == 2'h2 |=> read_data_o == 32'h0000_0000)
    else $error("write-only register read nonzero");
  // a write, one cycle with no write, then a read of reg0
  sequence s_ind_wr;
    write_i && indirect_i && addr_i == 2'h0;
  endsequence
  sequence s_no_wr;
    !write_i;
  endsequence
  sequence s_rd0;
    read_i && addr_i == 2'h0 && !write_i;
  endsequence
  ind_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_ind_wr ##1 s_no_wr ##1 s_rd0
    |=> read_data_o[11:8] == 4'h0 && read_data_o[27:24] == 4'h0 && read_data_o[15:14] == 2'h3)
    else $error("indirect write did not force reserved bits");
  direct_store_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    write_i && !indirect_i && addr_i == 2'h0 ##1 s_no_wr ##1 s_rd0
    |=> read_data_o[11:8] == $past(write_data_i[11:8], 3)
    && read_data_o[15:14] == $past(write_data_i[15:14], 3))
    else $error("direct write not read back");
  no_effect_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $past(context_reserved_i) |-> control_o[15:8] == 8'h00)
    else $error("reserved bit steered the device");
endmodule : rfb_bank

// ==== logic/rfb_pkg.sv ====
package rfb_pkg;
  localparam int unsigned data_width = 32;
  localparam int unsigned reg_count = 4;
  localparam int unsigned addr_width = 2;
  // per-bit field classes
  typedef enum logic [2:0] {
    rfb_normal,
    rfb_reads_as_zero_field,
    rfb_reads_as_one_field,
    rfb_reserved_zero_bit,
    rfb_reserved_one_bit,
    rfb_unknown_reading_field,
    rfb_context_bit
  } rfb_class_type;
  // tied or stored implementation of a reserved bit
  typedef enum logic {
    rfb_tied,
    rfb_stored
  } rfb_impl_type;
  localparam logic [31:0] reset_value = 32'h0000_0000;
  localparam logic [31:0] stored_one_reset = 32'hffff_ffff;
  localparam logic [31:0] zero_word = 32'h0000_0000;
  localparam logic [31:0] one_word = 32'hffff_ffff;
endpackage : rfb_pkg

// ==== logic/rfb_bit.sv ====
`timescale 1ns/1ps
module rfb_bit #(
  parameter rfb_pkg::rfb_class_type bit_class = rfb_pkg::rfb_normal,
  parameter rfb_pkg::rfb_impl_type bit_impl = rfb_pkg::rfb_stored,
  parameter logic reset_bit = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // write side
  input wire logic direct_write_i,
  input wire logic indirect_write_i,
  input wire logic write_data_i,
  input wire logic context_reserved_i,
  // read side
  output logic read_data_o,
  output logic function_o
);
  typedef struct packed {
    logic store;
  } rfb_bit_state_type;
  rfb_bit_state_type state;
  rfb_bit_state_type next_state;

  always_comb begin
    next_state = state;
    if (indirect_write_i) begin
      case (bit_class)
        rfb_pkg::rfb_reserved_zero_bit: next_state.store = 1'b0;
        rfb_pkg::rfb_reserved_one_bit: next_state.store = 1'b1;
        rfb_pkg::rfb_context_bit: next_state.store = context_reserved_i ? 1'b0 : write_data_i;
        default: next_state.store = write_data_i;
      endcase
    end else if (direct_write_i) begin
      next_state.store = write_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '{store: reset_bit};
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    case (bit_class)
      rfb_pkg::rfb_reads_as_zero_field: read_data_o = 1'b0;
      rfb_pkg::rfb_reads_as_one_field: read_data_o = 1'b1;
      rfb_pkg::rfb_unknown_reading_field: read_data_o = 1'b0;
      rfb_pkg::rfb_reserved_zero_bit:
        read_data_o = (bit_impl == rfb_pkg::rfb_tied) ? 1'b0 : state.store;
      rfb_pkg::rfb_reserved_one_bit:
        read_data_o = (bit_impl == rfb_pkg::rfb_tied) ? 1'b1 : state.store;
      default: read_data_o = state.store;
    endcase
  end

  always_comb begin
    case (bit_class)
      rfb_pkg::rfb_normal: function_o = state.store;
      rfb_pkg::rfb_context_bit: function_o = context_reserved_i ? 1'b0 : state.store;
      default: function_o = 1'b0;
    endcase
  end
endmodule : rfb_bit

// ==== tb/rfb_bank_tb_top.sv ====
`timescale 1ns/1ps
module rfb_bank_tb_top;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic write_i = 1'b0;
  logic indirect_i = 1'b0;
  logic read_i = 1'b0;
  logic context_reserved_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [31:0] write_data_i = 32'h0000_0000;
  logic [31:0] read_data_o;
  logic [31:0] control_o;
  logic read_valid_o;
  logic [31:0] m0, m3, got;
  logic [1:0] ra;
  int fail_count = 0;
  int total_checks = 0;
  int seed_val;
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  rfb_bank dut (.mclk_i(mclk_i), .reset_i(reset_i), .write_i(write_i), .indirect_i(indirect_i),
    .read_i(read_i), .addr_i(addr_i), .write_data_i(write_data_i),
    .context_reserved_i(context_reserved_i), .read_data_o(read_data_o),
    .read_valid_o(read_valid_o), .control_o(control_o));
  // expected read word for each register
  function automatic logic [31:0] exp_rd(input logic [1:0] a);
    case (a)
      2'h0: return (m0 & 32'h0f00_cfff) | 32'h00f0_3000;
      2'h1: return 32'hffff_0000;
      2'h3: return m3;
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_rd
  // software write word: reserved and fixed fields carry back the value read
  function automatic logic [31:0] sw_word(input logic [1:0] a, input logic [31:0] dd);
    logic [31:0] keep;
    case (a)
      2'h0: keep = 32'hffff_ff00;
      2'h3: keep = context_reserved_i ? 32'h0000_ffff : 32'h0000_0000;
      default: keep = 32'hffff_ffff;
    endcase
    return (dd & ~keep) | (exp_rd(a) & keep);
  endfunction : sw_word
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [1:0] a, input logic [31:0] dd, input logic ind);
    @(negedge mclk_i);
    write_i = 1'b1;
    indirect_i = ind;
    addr_i = a;
    write_data_i = dd;
    @(negedge mclk_i);
    write_i = 1'b0;
    indirect_i = 1'b0;
    write_data_i = ~dd;
    if (a == 2'h0) m0 = ind ? ((dd & 32'hf0ff_f0ff) | 32'h0000_c000) : dd;
    if (a == 2'h3) m3 = (ind && context_reserved_i) ? {dd[31:16], 16'h0000} : dd;
  endtask : wr
  task automatic rd(input logic [1:0] a);
    int k;
    @(negedge mclk_i);
    read_i = 1'b1;
    addr_i = a;
    @(negedge mclk_i);
    read_i = 1'b0;
    k = 0;
    while (read_valid_o !== 1'b1 && k < 4) begin
      @(negedge mclk_i);
      k++;
    end
    if (k == 4) begin
      fail_count++;
      wrap_up();
    end
    got = read_data_o;
  endtask : rd
  task automatic ctl_chk();
    if (context_reserved_i) chk(control_o, {m3[31:16], 8'h00, m0[7:0]});
    else chk(control_o, m3 | {24'h00_0000, m0[7:0]});
  endtask : ctl_chk
  initial begin
    seed_val = $urandom(32'ha866);
    m0 = 32'h0000_c000;
    m3 = 32'h0000_0000;
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0]);
      chk(got, exp_rd(a[1:0]));
    end
    $display("test reset_values done");
    for (int j = 0; j < 4; j++) begin
      for (int a = 0; a < 4; a++) begin
        wr(a[1:0], j[0] ? 32'hffff_ffff : 32'h0000_0000, j[1]);
        rd(a[1:0]);
        chk(got, exp_rd(a[1:0]));
      end
    end
    $display("test fixed_patterns done");
    context_reserved_i = 1'b1;
    wr(2'h0, 32'hffff_ffff, 1'b0);
    for (int j = 0; j < 2; j++) begin
      wr(2'h3, 32'hffff_ffff, j[0]);
      rd(2'h3);
      chk(got, exp_rd(2'h3));
      ctl_chk();
    end
    wr(2'h3, 32'h5a5a_a5a5, 1'b0);
    context_reserved_i = 1'b0;
    rd(2'h3);
    chk(got, 32'h5a5a_a5a5);
    ctl_chk();
    $display("test context_bits done");
    for (int n = 0; n < 60; n++) begin
      context_reserved_i = 1'($urandom());
      ra = 2'($urandom());
      wr(ra, sw_word(ra, $urandom()), 1'($urandom()));
      rd(ra);
      chk(got, exp_rd(ra));
      ctl_chk();
    end
    $display("test random_traffic done");
    wrap_up();
  end
endmodule : rfb_bank_tb_top
